// ---- hw/phase_shed_map.vh ----
`ifndef PHASE_SHED_MAP_VH
`define PHASE_SHED_MAP_VH
// Command codes on page 0
`define CMD_PAGE_RAIL1 8'h00
`define CMD_VALLEY_LIMIT 8'hda
`define CMD_SHED_CTRL 8'hdb
// Valley limit register fields
`define VL_THR_MSB 6
`define VL_THR_LSB 0
`define VL_SS_BIT 7
`define VL_WRITE_MASK 16'h00ff
`define VL_RESET 16'h0000
// Shed control register fields
`define SC_EXIT_DLY_MSB 15
`define SC_EXIT_DLY_LSB 12
`define SC_ANY_EXIT_BIT 11
`define SC_FREQ_EXIT_BIT 10
`define SC_ONE_EXIT_BIT 9
`define SC_UNDER_EXIT_BIT 8
`define SC_ENTRY_MSB 7
`define SC_ENTRY_LSB 2
`define SC_STEP_BIT 1
`define SC_EN_BIT 0
`define SC_RESET 16'h0000
// Timing
`define CLK_NS 20
`define EXIT_STEP_NS 100
`define EXIT_OFS_NS 50
`define ONCE_SHED_NS 16000
`define EXIT_STEP_CYC ((`EXIT_STEP_NS + `CLK_NS - 1) / `CLK_NS)
`define EXIT_OFS_CYC ((`EXIT_OFS_NS + `CLK_NS - 1) / `CLK_NS)
`define ONCE_SHED_CYC ((`ONCE_SHED_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// ---- hw/valley_limit_phase.v ----
`timescale 1ns/1ps
`default_nettype none
// Per-phase valley current limiter: holds pulse low while current stays over threshold after an off-time excess
module valley_limit_phase #(
  parameter CW = 8
) (
  // Clock and reset
  input wire mclk,
  input wire rst_sync_n,
  // Phase inputs
  input wire pulse_req,
  input wire [CW-1:0] phase_current,
  input wire [6:0] threshold,
  input wire limit_active,
  // Outputs
  output reg pulse_out,
  output reg limit_hit
);
  // Over-threshold compare, zero-extended threshold
  wire over = phase_current > {{(CW-7){1'b0}}, threshold};
  // Latched clamp state
  reg clamp;

  // Clamp set during off time, held until current falls back
  always @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      clamp <= 1'b0;
      pulse_out <= 1'b0;
      limit_hit <= 1'b0;
    end else begin
      if (!limit_active || !over) begin
        clamp <= 1'b0;
      end else if (!pulse_req || clamp) begin
        clamp <= 1'b1;
      end
      limit_hit <= limit_active && over && !pulse_req && !clamp;
      pulse_out <= pulse_req && !(clamp && over && limit_active);
    end
  end
endmodule // valley_limit_phase
`default_nettype wire

// ---- hw/phase_limit_shed_ctrl.v ----
`timescale 1ns/1ps
`default_nettype none
`include "phase_shed_map.vh"
// Function
// - Valley register on rail 1, page 0
// - Threshold bits 6:0, one amp per step
// - Over threshold off-time holds pulse low
// - Bit 7 set suppresses limit in softstart
// - Bits 15:8 write-ignored, read zero
// - Limit-to-exit delay 100ns steps plus 50ns
// - Bit 11: limit exits from any state
// - Bit 10: frequency rise exits shed
// - Bit 9: limit exits single-phase only
// - Bit 8: undershoot forces full phase
// - Enter shed after N low report periods
// - Bit 1: stepwise or 16us direct
// - Bit 0 enables automatic shedding
module phase_limit_shed_ctrl #(
  parameter NPH = 4,
  parameter CW = 8,
  parameter LW = 8,
  parameter STEP_DLY_CYC = 16'd50
) (
  // Clock and reset
  input wire mclk,
  input wire rst_n,
  // Register command port
  input wire [7:0] cmd_page,
  input wire [7:0] cmd_code,
  input wire cmd_wr,
  input wire [15:0] cmd_wdata,
  output reg [15:0] cmd_rdata,
  // Phase pulses and currents
  input wire [NPH-1:0] pulse_req,
  input wire [NPH*CW-1:0] phase_current,
  output wire [NPH-1:0] pulse_out,
  // Rail status inputs from pins
  input wire softstart,
  input wire freq_rise,
  input wire feedback_under,
  input wire report_tick,
  input wire [LW-1:0] load_current,
  input wire [LW-1:0] shed_threshold,
  input wire [2:0] target_phases,
  // Shed state
  output reg [2:0] active_phases,
  output reg auto_shed_mode
);
  // Reset synchroniser
  reg rst_m;
  reg rst_sync_n;
  // Registers
  reg [7:0] phase_valley_limit_cfg;
  reg [15:0] phase_shedding_ctrl;
  // Pin synchronisers: softstart, freq_rise, feedback_under, report_tick
  reg [3:0] pin_m;
  reg [3:0] pin_s;
  reg tick_d;
  // Entry counter, exit and step timers
  reg [5:0] low_count;
  reg exit_pend;
  reg [7:0] exit_timer;
  reg [15:0] step_timer;
  // Per-phase limit hits
  wire [NPH-1:0] limit_hit;
  wire limit_any = |limit_hit;
  wire ss = pin_s[0];
  wire tick = pin_s[3] && !tick_d;

  // Field views
  wire [3:0] exit_dly = phase_shedding_ctrl[`SC_EXIT_DLY_MSB:`SC_EXIT_DLY_LSB];
  wire [5:0] entry_n = phase_shedding_ctrl[`SC_ENTRY_MSB:`SC_ENTRY_LSB];
  wire shed_enable = phase_shedding_ctrl[`SC_EN_BIT];
  wire shed_step_select = phase_shedding_ctrl[`SC_STEP_BIT];
  // Exit delay in cycles: steps of 100 ns plus 50 ns offset, worked at full width
  wire [31:0] exit_cyc_wide = exit_dly * `EXIT_STEP_CYC + `EXIT_OFS_CYC;
  // Largest setting is 78 cycles, so the low byte always holds it
  wire [7:0] exit_cyc = exit_cyc_wide[7:0];
  // Direct shed wait, cut to the step timer's width on purpose
  wire [31:0] once_cyc_wide = `ONCE_SHED_CYC;
  wire [15:0] once_cyc = once_cyc_wide[15:0];

  // Reset release through two flops
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_m <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_m <= 1'b1;
      rst_sync_n <= rst_m;
    end
  end

  // Two-flop synchronisers for the external status levels
  always @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pin_m <= 4'h0;
      pin_s <= 4'h0;
      tick_d <= 1'b0;
    end else begin
      pin_m <= {report_tick, feedback_under, freq_rise, softstart};
      pin_s <= pin_m;
      tick_d <= pin_s[3];
    end
  end

  // Register writes; only page 0 decodes
  always @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      phase_valley_limit_cfg <= 8'h00;
      phase_shedding_ctrl <= `SC_RESET;
    end else if (cmd_wr && cmd_page == `CMD_PAGE_RAIL1) begin
      if (cmd_code == `CMD_VALLEY_LIMIT) begin
        phase_valley_limit_cfg <= cmd_wdata[7:0];
      end
      if (cmd_code == `CMD_SHED_CTRL) begin
        phase_shedding_ctrl <= cmd_wdata;
      end
    end
  end

  // Registered readback; unknown codes read zero
  always @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cmd_rdata <= 16'h0000;
    end else if (cmd_page != `CMD_PAGE_RAIL1) begin
      cmd_rdata <= 16'h0000;
    end else if (cmd_code == `CMD_VALLEY_LIMIT) begin
      cmd_rdata <= {8'h00, phase_valley_limit_cfg};
    end else if (cmd_code == `CMD_SHED_CTRL) begin
      cmd_rdata <= phase_shedding_ctrl;
    end else begin
      cmd_rdata <= 16'h0000;
    end
  end

  wire limit_active = !(ss && phase_valley_limit_cfg[`VL_SS_BIT]);

  // One limiter per phase
  genvar g;
  generate
    for (g = 0; g < NPH; g = g + 1) begin : ph
      valley_limit_phase #(.CW(CW)) u_lim (
        .mclk(mclk),
        .rst_sync_n(rst_sync_n),
        .pulse_req(pulse_req[g]),
        .phase_current(phase_current[g*CW +: CW]),
        .threshold(phase_valley_limit_cfg[`VL_THR_MSB:`VL_THR_LSB]),
        .limit_active(limit_active),
        .pulse_out(pulse_out[g]),
        .limit_hit(limit_hit[g])
      );
    end
  endgenerate

  // Exit qualifiers: limit-triggered, frequency rise, undershoot
  // any-state exit
  wire any_trig = phase_shedding_ctrl[`SC_ANY_EXIT_BIT] && limit_any;
  wire one_trig = phase_shedding_ctrl[`SC_ONE_EXIT_BIT] && limit_any && active_phases == 3'd1;
  wire freq_exit = phase_shedding_ctrl[`SC_FREQ_EXIT_BIT] && pin_s[1];
  wire under_exit = phase_shedding_ctrl[`SC_UNDER_EXIT_BIT] && pin_s[2];
  // Exit timer expiry
  wire limit_exit = exit_pend && exit_timer == 8'd0;
  wire go_full = !shed_enable || freq_exit || under_exit || limit_exit;
  wire [2:0] full = NPH[2:0];

  // Shedding state machine
  always @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      low_count <= 6'd0;
      exit_pend <= 1'b0;
      exit_timer <= 8'd0;
      step_timer <= 16'd0;
      active_phases <= NPH[2:0];
      auto_shed_mode <= 1'b0;
    end else begin
      if (auto_shed_mode && !exit_pend && (any_trig || one_trig)) begin
        exit_pend <= 1'b1;
        exit_timer <= exit_cyc;
      end else if (exit_pend && exit_timer != 8'd0) begin
        exit_timer <= exit_timer - 8'd1;
      end else begin
        exit_pend <= 1'b0;
      end
      if (go_full) begin
        auto_shed_mode <= 1'b0;
        active_phases <= full;
        low_count <= 6'd0;
        step_timer <= 16'd0;
      end else if (!auto_shed_mode) begin
        // Count consecutive low report samples
        if (tick) begin
          if (load_current >= shed_threshold) begin
            low_count <= 6'd0;
          end else if (low_count + 6'd1 >= entry_n) begin
            auto_shed_mode <= 1'b1;
            low_count <= 6'd0;
            step_timer <= shed_step_select ? once_cyc : STEP_DLY_CYC;
          end else begin
            low_count <= low_count + 6'd1;
          end
        end
      end else if (active_phases > target_phases && target_phases != 3'd0) begin
        if (step_timer != 16'd0) begin
          step_timer <= step_timer - 16'd1;
        end else if (shed_step_select) begin
          active_phases <= target_phases;
        end else begin
          active_phases <= active_phases - 3'd1;
          step_timer <= STEP_DLY_CYC;
        end
      end
    end
  end
endmodule // phase_limit_shed_ctrl
`default_nettype wire

// ---- tb/shed_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
// Port-level checks on readback, pulse gating and shed state
module shed_sva #(parameter NPH = 4, parameter CW = 8) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] cmd_page,
  input wire logic [7:0] cmd_code,
  input wire logic cmd_wr,
  input wire logic [15:0] cmd_wdata,
  input wire logic [15:0] cmd_rdata,
  // Phases and shed state
  input wire logic [NPH-1:0] pulse_req,
  input wire logic [NPH*CW-1:0] phase_current,
  input wire logic [NPH-1:0] pulse_out,
  input wire logic [2:0] active_phases,
  input wire logic auto_shed_mode
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Write a code, then present it again for readback
  sequence wr_rd(c);
    cmd_wr && cmd_page == 8'h00 && cmd_code == c ##1 !cmd_wr && cmd_page == 8'h00 && cmd_code == c;
  endsequence
  vl_rdbk_a: assert property (wr_rd(8'hda) |=> cmd_rdata == ($past(cmd_wdata, 2) & 16'h00ff))
    else $error("valley word readback wrong");
  sc_rdbk_a: assert property (wr_rd(8'hdb) |=> cmd_rdata == $past(cmd_wdata, 2))
    else $error("shed word readback wrong");
  rsvd_zero_a: assert property (cmd_code == 8'hda |=> cmd_rdata[15:8] == 8'h00)
    else $error("reserved bits not zero");
  bad_page_a: assert property (cmd_page != 8'h00 |=> cmd_rdata == 16'h0000)
    else $error("other page reads nonzero");
  bad_code_a: assert property (cmd_code != 8'hda && cmd_code != 8'hdb |=> cmd_rdata == 16'h0000)
    else $error("unmapped code reads nonzero");
  pulse_gate_a: assert property ((pulse_out & ~$past(pulse_req)) == '0)
    else $error("pulse without request");
  pulse_pass_a: assert property ($past(phase_current) == '0 && $past(phase_current, 2) == '0 && !auto_shed_mode && !$past(auto_shed_mode) |-> pulse_out == $past(pulse_req))
    else $error("pulse held low at zero current");
  full_idle_a: assert property (!auto_shed_mode [*3] |-> active_phases == NPH)
    else $error("phases missing outside shed");
endmodule // shed_sva
`default_nettype wire

// ---- tb/power_stage_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Power stages: current ramps while the pulse is high and drains while low
module power_stage_model #(parameter NPH = 4, parameter CW = 8, parameter RISE = 2) (
  // Clock
  input wire logic mclk,
  // Pulses in, sensed currents out
  input wire logic [NPH-1:0] pulse_out,
  output var logic [NPH*CW-1:0] phase_current
);
  int cur [NPH];
  initial phase_current = '0;
  // One current step per cycle, capped well inside the field
  always @(posedge mclk) begin
    for (int g = 0; g < NPH; g++) begin
      if (pulse_out[g]) cur[g] <= (cur[g] > 190) ? 200 : cur[g] + RISE;
      else cur[g] <= (cur[g] > 0) ? cur[g] - 1 : 0;
      phase_current[g*CW +: CW] <= CW'(cur[g]);
    end
  end
endmodule // power_stage_model
`default_nettype wire

// ---- tb/phase_limit_shed_ctrl_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
// Bench: register model, valley clamp, shed entry and exits
module phase_limit_shed_ctrl_tb;
  logic mclk = 0, rst_n = 0, cmd_wr = 0, softstart = 0, freq_rise = 0, feedback_under = 0;
  logic report_tick = 0;
  logic [7:0] cmd_page = 8'h00, cmd_code = 8'h00, load_current = 8'h10, shed_threshold = 8'h40;
  logic [15:0] cmd_wdata = 16'h0000, rd;
  logic [3:0] pulse_req = 4'h0;
  logic [2:0] target_phases = 3'h1;
  logic [15:0] xbit [3] = '{16'h040b, 16'h010b, 16'h280b};
  wire [15:0] cmd_rdata;
  wire [3:0] pulse_out;
  wire [31:0] phase_current;
  wire [2:0] active_phases;
  wire auto_shed_mode;
  int n_fail = 0, checks_done = 0, cycles = 0, seed = 48, vl_m = 0, sc_m = 0;
  always #10 mclk = ~mclk;
  phase_limit_shed_ctrl #(.NPH(4), .CW(8)) phase_limit_shed_ctrl_inst (.mclk(mclk),
    .rst_n(rst_n), .cmd_page(cmd_page), .cmd_code(cmd_code), .cmd_wr(cmd_wr),
    .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .pulse_req(pulse_req),
    .phase_current(phase_current), .pulse_out(pulse_out), .softstart(softstart),
    .freq_rise(freq_rise), .feedback_under(feedback_under), .report_tick(report_tick),
    .load_current(load_current), .shed_threshold(shed_threshold),
    .target_phases(target_phases), .active_phases(active_phases),
    .auto_shed_mode(auto_shed_mode));
  power_stage_model power_stage_model_inst (.mclk(mclk), .pulse_out(pulse_out),
    .phase_current(phase_current));
  // Verdict and end of run
  task automatic report_and_stop;
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    checks_done++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  // Access, then compare against the register model
  task automatic reg_io(input logic [7:0] p, c, input logic w, input logic [15:0] d);
    @(negedge mclk);
    {cmd_page, cmd_code, cmd_wr, cmd_wdata} = {p, c, w, d};
    @(negedge mclk);
    cmd_wr = 1'b0;
    repeat (2) @(negedge mclk);
    rd = cmd_rdata;
    cmd_page = 8'h00;
    if (w && p == 8'h00 && c == 8'hda) vl_m = d & 16'h00ff;
    if (w && p == 8'h00 && c == 8'hdb) sc_m = d;
    chk(rd === ((p != 8'h00) ? 16'h0000 : (c == 8'hda) ? 16'(vl_m) :
      (c == 8'hdb) ? 16'(sc_m) : 16'h0000), "readback");
  endtask
  // One report period with the given load
  task automatic tick(input logic [7:0] ld);
    load_current = ld;
    repeat (4) @(negedge mclk);
    report_tick = 1'b1;
    repeat (6) @(negedge mclk);
    report_tick = 1'b0;
  endtask
  // Wait, bounded, for mode and phase count
  task automatic wait_st(input logic [3:0] w, input int lim);
    for (int k = 0; k < lim && {auto_shed_mode, active_phases} !== w; k++) @(negedge mclk);
    chk({auto_shed_mode, active_phases} === w, "shed state");
  endtask
  // Charge phase 0, release, request again while still over threshold
  task automatic lim_run(input logic clamp);
    pulse_req[0] = 1'b1;
    repeat (20) @(negedge mclk);
    pulse_req[0] = 1'b0;
    repeat (2) @(negedge mclk);
    pulse_req[0] = 1'b1;
    repeat (3) @(negedge mclk);
    chk(pulse_out[0] === !clamp, "clamp state");
    for (int k = 0; k < 100 && pulse_out[0] !== 1'b1; k++) @(negedge mclk);
    if (clamp) chk(pulse_out[0] === 1'b1 && phase_current[7:0] <= 8'h06, "clamp release");
    pulse_req[0] = 1'b0;
    repeat (60) @(negedge mclk);
  endtask
  // Exit causes: frequency rise, undershoot, limit burst on phase 0
  task automatic cause(input int k, input logic v);
    if (k == 0) freq_rise = v;
    if (k == 1) feedback_under = v;
    if (k == 2 && v) lim_run(1'b1);
  endtask
  // Cycle ceiling against hangs
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 10000) begin
      n_fail++;
      report_and_stop();
    end
  end
  initial begin
    repeat (4) @(negedge mclk);
    rst_n = 1'b1;
    repeat (3) @(negedge mclk);
    wait_st(4'h4, 1);
    reg_io(8'h00, 8'hdb, 1'b0, 16'h0000);
    for (int i = 0; i < 6; i++) reg_io(8'h00, i[0] ? 8'hdb : 8'hda, 1'b1, 16'($random(seed)));
    reg_io(8'h01, 8'hda, 1'b1, 16'h00ff);
    reg_io(8'h00, 8'hdc, 1'b1, 16'h1234);
    reg_io(8'h00, 8'hda, 1'b1, 16'hff06);
    lim_run(1'b1);
    softstart = 1'b1;
    lim_run(1'b1);
    reg_io(8'h00, 8'hda, 1'b1, 16'h0086);
    lim_run(1'b0);
    softstart = 1'b0;
    reg_io(8'h00, 8'hdb, 1'b1, 16'h000b);
    tick(8'h10);
    tick(8'h50);
    tick(8'h10);
    chk(auto_shed_mode === 1'b0, "early shed");
    tick(8'h10);
    repeat (4) @(negedge mclk);
    chk(auto_shed_mode === 1'b1, "shed entry");
    repeat (700) @(negedge mclk);
    chk(active_phases === 3'h4, "direct delay");
    wait_st(4'h9, 200);
    for (int k = 0; k < 3; k++) begin
      cause(k, 1'b1);
      repeat (30) @(negedge mclk);
      chk(auto_shed_mode === 1'b1, "exit while off");
      cause(k, 1'b0);
      reg_io(8'h00, 8'hdb, 1'b1, xbit[k]);
      cause(k, 1'b1);
      wait_st(4'h4, 60);
      cause(k, 1'b0);
      reg_io(8'h00, 8'hdb, 1'b1, 16'h000b);
      tick(8'h10);
      tick(8'h10);
    end
    wait_st(4'h9, 900);
    reg_io(8'h00, 8'hdb, 1'b1, 16'h220b);
    pulse_req[0] = 1'b1;
    repeat (20) @(negedge mclk);
    pulse_req[0] = 1'b0;
    repeat (12) @(negedge mclk);
    chk(auto_shed_mode === 1'b1, "limit exit early");
    repeat (8) @(negedge mclk);
    chk({auto_shed_mode, active_phases} === 4'h4, "single-phase exit");
    repeat (60) @(negedge mclk);
    reg_io(8'h00, 8'hdb, 1'b1, 16'h0009);
    tick(8'h10);
    tick(8'h10);
    chk({auto_shed_mode, active_phases} === 4'hc, "step delay");
    wait_st(4'hb, 60);
    wait_st(4'h9, 120);
    reg_io(8'h00, 8'hdb, 1'b1, 16'h000a);
    wait_st(4'h4, 60);
    report_and_stop();
  end
endmodule // phase_limit_shed_ctrl_tb
bind phase_limit_shed_ctrl shed_sva #(.NPH(NPH), .CW(CW)) shed_sva_inst (.mclk(mclk),
  .rst_n(rst_n), .cmd_page(cmd_page), .cmd_code(cmd_code), .cmd_wr(cmd_wr),
  .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .pulse_req(pulse_req),
  .phase_current(phase_current), .pulse_out(pulse_out), .active_phases(active_phases),
  .auto_shed_mode(auto_shed_mode));
`default_nettype wire
